// ### core/fdi_pkg.sv
// Purpose: Shared constants for the data-phase inversion and strobe link.
// Assumes: 64-bit data in four 16-bit groups; one system clock of 125 MHz.
// Notes: Link wires are active high here; pin polarity lives outside.
package fdi_pkg;
   localparam int GROUPS = 4;
   localparam int GROUP_W = 16;
   localparam int DATA_W = GROUPS * GROUP_W;
   localparam int HALF_GROUP = GROUP_W / 2;
   localparam int CLK_PERIOD_NS = 8;
   // One strobe phase lasts this many nanoseconds; each phase spans two system clocks.
   localparam int PHASE_NS = 16;
   localparam int PHASE_CYC = (PHASE_NS / CLK_PERIOD_NS) < 1 ? 1 : (PHASE_NS / CLK_PERIOD_NS);
   localparam int BEATS = 4;
   localparam logic [1:0] SLEEP_CODE = 2'h0;
   localparam logic [1:0] DEEP_CODE = 2'h1;
   typedef enum logic [1:0]
   {
      FDI_SLEEP = 2'b00,
      FDI_DEEP = 2'b01,
      FDI_RUN = 2'b10
   } fdi_power_e;
endpackage

// ### core/fdi_link_if.sv
// Purpose: Link wires between the processor end and the chipset end.
// Assumes: Each end drives data only while its enable is high.
// Notes: Resolved wires are the OR of the two drivers gated by enables.
`timescale 1ns/1ps
`default_nettype none
interface fdi_link_if;
   import fdi_pkg::*;
   logic [DATA_W-1:0] devData;
   logic [DATA_W-1:0] hubData;
   logic [GROUPS-1:0] devPolarity;
   logic [GROUPS-1:0] hubPolarity;
   logic devValid;
   logic hubValid;
   logic [GROUPS-1:0] devPosStrobe;
   logic [GROUPS-1:0] hubPosStrobe;
   logic [GROUPS-1:0] devNegStrobe;
   logic [GROUPS-1:0] hubNegStrobe;
   logic devOe;
   logic hubOe;
   logic deepSleepRequest;
   logic dataInputPowerCut;
   logic [DATA_W-1:0] data;
   logic [GROUPS-1:0] groupPolarityFlag;
   logic dataValidMark;
   logic [GROUPS-1:0] posDataStrobe;
   logic [GROUPS-1:0] negDataStrobe;
   assign data = (devOe ? devData : '0) | (hubOe ? hubData : '0);
   assign groupPolarityFlag = (devOe ? devPolarity : '0) | (hubOe ? hubPolarity : '0);
   assign dataValidMark = (devOe & devValid) | (hubOe & hubValid);
   assign posDataStrobe = (devOe ? devPosStrobe : '0) | (hubOe ? hubPosStrobe : '0);
   assign negDataStrobe = (devOe ? devNegStrobe : '0) | (hubOe ? hubNegStrobe : '0);
   modport dev
   (
      input data, groupPolarityFlag, dataValidMark, posDataStrobe, negDataStrobe,
      input deepSleepRequest, dataInputPowerCut,
      output devData, devPolarity, devValid, devPosStrobe, devNegStrobe, devOe
   );
   modport hub
   (
      input data, groupPolarityFlag, dataValidMark, posDataStrobe, negDataStrobe,
      output deepSleepRequest, dataInputPowerCut,
      output hubData, hubPolarity, hubValid, hubPosStrobe, hubNegStrobe, hubOe
   );
endinterface
`default_nettype wire

// ### core/fdi_end.sv
// Purpose: One data-phase end: inverting quad-pumped sender and strobe receiver.
// Assumes: Link inputs are asynchronous and pass two flops before use.
// Notes: IS_DEVICE selects processor behaviour (sleep states, buffer power cut).
`timescale 1ns/1ps
`default_nettype none
module fdi_end #(
   parameter bit IS_DEVICE = 1'b1
)
(
   // Link
   input wire logic [fdi_pkg::DATA_W-1:0] linkData,
   input wire logic [fdi_pkg::GROUPS-1:0] linkPolarity,
   input wire logic linkValid,
   input wire logic [fdi_pkg::GROUPS-1:0] linkPosStrobe,
   input wire logic [fdi_pkg::GROUPS-1:0] linkNegStrobe,
   input wire logic sleepReqIn,
   input wire logic powerCutIn,
   output logic [fdi_pkg::DATA_W-1:0] outData,
   output logic [fdi_pkg::GROUPS-1:0] outPolarity,
   output logic outValid,
   output logic [fdi_pkg::GROUPS-1:0] outPosStrobe,
   output logic [fdi_pkg::GROUPS-1:0] outNegStrobe,
   output logic outOe,
   // User send side
   input wire logic clk,
   input wire logic nrst,
   input wire logic sendValid,
   input wire logic [fdi_pkg::DATA_W-1:0] sendWord,
   output logic sendReady,
   // User receive side
   output logic [fdi_pkg::DATA_W-1:0] recvWord,
   output logic recvValid,
   output logic deepSleep,
   output logic inputBufOff
);
   import fdi_pkg::*;
   typedef enum logic [1:0]
   {
      FDI_IDLE = 2'b00,
      FDI_SEND = 2'b01
   } fdi_tx_e;
   fdi_tx_e txState_reg;
   logic [$clog2(PHASE_CYC+1)-1:0] phaseCnt_reg;
   logic [1:0] beat_reg;
   logic [DATA_W-1:0] lastBus_reg;
   logic [DATA_W-1:0] wireData;
   logic [GROUPS-1:0] wireInv;
   logic phaseTick;
   assign phaseTick = (phaseCnt_reg == ($clog2(PHASE_CYC+1))'(PHASE_CYC - 1));
   // The word is held for four beats; each beat re-encodes against the previous bus value.
   for (genvar g = 0; g < GROUPS; g++)
   begin : gEnc
      logic [GROUP_W-1:0] plain;
      logic [GROUP_W-1:0] prev;
      logic [$clog2(GROUP_W+1)-1:0] changes;
      assign plain = sendWord[g*GROUP_W +: GROUP_W];
      assign prev = lastBus_reg[g*GROUP_W +: GROUP_W];
      assign changes = ($clog2(GROUP_W+1))'($countones(plain ^ prev));
      assign wireInv[g] = changes > ($clog2(GROUP_W+1))'(HALF_GROUP);
      assign wireData[g*GROUP_W +: GROUP_W] = wireInv[g] ? ~plain : plain;
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txState_reg <= FDI_IDLE;
         phaseCnt_reg <= '0;
         beat_reg <= 2'h0;
         lastBus_reg <= '0;
         outData <= '0;
         outPolarity <= '0;
         outValid <= 1'b0;
         outPosStrobe <= '0;
         outNegStrobe <= '0;
         outOe <= 1'b0;
         sendReady <= 1'b0;
      end
      else
      begin
         sendReady <= 1'b0;
         unique case (txState_reg)
            FDI_IDLE:
            begin
               outValid <= 1'b0;
               outOe <= 1'b0;
               outPosStrobe <= '0;
               outNegStrobe <= '0;
               // The request still stands in the cycle that ready is seen; taking it again
               // would send the same word twice.
               if (sendValid && !sendReady)
               begin
                  txState_reg <= FDI_SEND;
                  phaseCnt_reg <= '0;
                  beat_reg <= 2'h0;
                  outData <= wireData;
                  outPolarity <= wireInv;
                  lastBus_reg <= wireData;
                  outValid <= 1'b1;
                  outOe <= 1'b1;
               end
            end
            FDI_SEND:
            begin
               if (!phaseTick)
                  phaseCnt_reg <= phaseCnt_reg + 1'b1;
               else
               begin
                  phaseCnt_reg <= '0;
                  // Odd beats fall on the negative strobe, even on the positive one.
                  if (beat_reg[0])
                     outNegStrobe <= '1;
                  else
                     outPosStrobe <= '1;
                  if (beat_reg == 2'h3)
                  begin
                     txState_reg <= FDI_IDLE;
                     sendReady <= 1'b1;
                  end
                  else
                     beat_reg <= beat_reg + 2'h1;
               end
               // A new beat goes out as the strobe drops, so data never moves under a rising strobe.
               if (phaseCnt_reg == '0 && beat_reg != 2'h0)
               begin
                  outPosStrobe <= '0;
                  outNegStrobe <= '0;
                  outData <= wireData;
                  outPolarity <= wireInv;
                  lastBus_reg <= wireData;
               end
            end
            default: txState_reg <= FDI_IDLE;
         endcase
      end
   end
   // Receive path: all link inputs cross into clk through two flops.
   localparam int SW = DATA_W + 3 * GROUPS + 3;
   logic [SW-1:0] syncA_reg;
   logic [SW-1:0] syncB_reg;
   logic [GROUPS-1:0] posPrev_reg;
   logic [GROUPS-1:0] negPrev_reg;
   // Own drive enable delayed to line up with the two sync stages of the link inputs.
   logic [1:0] ownOeHist_reg;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         syncA_reg <= '0;
         syncB_reg <= '0;
      end
      else
      begin
         syncA_reg <= {linkData, linkPolarity, linkValid, linkPosStrobe, linkNegStrobe,
                       sleepReqIn, powerCutIn};
         syncB_reg <= syncA_reg;
      end
   end
   logic [DATA_W-1:0] sData;
   logic [GROUPS-1:0] sPol;
   logic sValid;
   logic [GROUPS-1:0] sPos;
   logic [GROUPS-1:0] sNeg;
   logic sSleep;
   logic sCut;
   assign {sData, sPol, sValid, sPos, sNeg, sSleep, sCut} = syncB_reg;
   logic [GROUPS-1:0] fall;
   logic [DATA_W-1:0] restored;
   for (genvar g = 0; g < GROUPS; g++)
   begin : gDec
      // Strobes are active-high internally; a falling strobe pin is a rising edge here.
      assign fall[g] = (sPos[g] & ~posPrev_reg[g]) | (sNeg[g] & ~negPrev_reg[g]);
      assign restored[g*GROUP_W +: GROUP_W] = sPol[g] ? ~sData[g*GROUP_W +: GROUP_W]
                                                      : sData[g*GROUP_W +: GROUP_W];
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         posPrev_reg <= '0;
         negPrev_reg <= '0;
         ownOeHist_reg <= 2'h0;
         recvWord <= '0;
         recvValid <= 1'b0;
      end
      else
      begin
         posPrev_reg <= sPos;
         negPrev_reg <= sNeg;
         ownOeHist_reg <= {ownOeHist_reg[0], outOe};
         recvValid <= 1'b0;
         // A beat counts only when every group strobed, the mark is up and buffers are on.
         if (&fall && sValid && !inputBufOff && !outOe && ownOeHist_reg == 2'h0)
         begin
            recvWord <= restored;
            recvValid <= 1'b1;
         end
      end
   end
   // Power states: only the processor end follows the chipset's requests.
   fdi_power_e power_reg;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         power_reg <= FDI_SLEEP;
         deepSleep <= 1'b0;
         inputBufOff <= 1'b0;
      end
      else
      begin
         if (IS_DEVICE)
         begin
            if (power_reg == FDI_SLEEP && sSleep)
               power_reg <= FDI_DEEP;
            else if (power_reg == FDI_DEEP && !sSleep)
               power_reg <= FDI_SLEEP;
            deepSleep <= (power_reg == FDI_DEEP);
            inputBufOff <= sCut;
         end
         else
         begin
            power_reg <= FDI_SLEEP;
            deepSleep <= 1'b0;
            inputBufOff <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### core/fdi_dev_end.sv
// Purpose: Processor end wrapper and chipset end with sleep controls.
// Assumes: Both ends share the data-phase engine in fdi_end.
// Notes: The chipset end drives the deep-sleep and power-cut wires from flops.
`timescale 1ns/1ps
`default_nettype none
module fdi_dev_end
(
   // Link
   fdi_link_if.dev link,
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // User
   input wire logic sendValid,
   input wire logic [fdi_pkg::DATA_W-1:0] sendWord,
   output logic sendReady,
   output logic [fdi_pkg::DATA_W-1:0] recvWord,
   output logic recvValid,
   output logic deepSleep,
   output logic inputBufOff
);
   import fdi_pkg::*;
   fdi_end #(.IS_DEVICE(1'b1)) uEnd
   (
      .linkData(link.data),
      .linkPolarity(link.groupPolarityFlag),
      .linkValid(link.dataValidMark),
      .linkPosStrobe(link.posDataStrobe),
      .linkNegStrobe(link.negDataStrobe),
      .sleepReqIn(link.deepSleepRequest),
      .powerCutIn(link.dataInputPowerCut),
      .outData(link.devData),
      .outPolarity(link.devPolarity),
      .outValid(link.devValid),
      .outPosStrobe(link.devPosStrobe),
      .outNegStrobe(link.devNegStrobe),
      .outOe(link.devOe),
      .clk(clk),
      .nrst(nrst),
      .sendValid(sendValid),
      .sendWord(sendWord),
      .sendReady(sendReady),
      .recvWord(recvWord),
      .recvValid(recvValid),
      .deepSleep(deepSleep),
      .inputBufOff(inputBufOff)
   );
endmodule
module fdi_hub_end
(
   // Link
   fdi_link_if.hub link,
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // User
   input wire logic sendValid,
   input wire logic [fdi_pkg::DATA_W-1:0] sendWord,
   output logic sendReady,
   output logic [fdi_pkg::DATA_W-1:0] recvWord,
   output logic recvValid,
   input wire logic askDeepSleep,
   input wire logic askPowerCut
);
   import fdi_pkg::*;
   logic sleepOut_reg;
   logic cutOut_reg;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sleepOut_reg <= 1'b0;
         cutOut_reg <= 1'b0;
      end
      else
      begin
         sleepOut_reg <= askDeepSleep;
         cutOut_reg <= askPowerCut;
      end
   end
   assign link.deepSleepRequest = sleepOut_reg;
   assign link.dataInputPowerCut = cutOut_reg;
   fdi_end #(.IS_DEVICE(1'b0)) uEnd
   (
      .linkData(link.data),
      .linkPolarity(link.groupPolarityFlag),
      .linkValid(link.dataValidMark),
      .linkPosStrobe(link.posDataStrobe),
      .linkNegStrobe(link.negDataStrobe),
      .sleepReqIn(1'b0),
      .powerCutIn(1'b0),
      .outData(link.hubData),
      .outPolarity(link.hubPolarity),
      .outValid(link.hubValid),
      .outPosStrobe(link.hubPosStrobe),
      .outNegStrobe(link.hubNegStrobe),
      .outOe(link.hubOe),
      .clk(clk),
      .nrst(nrst),
      .sendValid(sendValid),
      .sendWord(sendWord),
      .sendReady(sendReady),
      .recvWord(recvWord),
      .recvValid(recvValid),
      .deepSleep(),
      .inputBufOff()
   );
endmodule
`default_nettype wire

// ### dv/fdi_link_chk.sv
// Purpose: Wire checks on the joined link.
// Assumes: Link wires active high; one clock.
// Notes: A strobe phase lasts two clocks.
`timescale 1ns/1ps
`default_nettype none
module fdi_link_chk
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Resolved link
   input wire logic [fdi_pkg::DATA_W-1:0] data,
   input wire logic [fdi_pkg::GROUPS-1:0] groupPolarityFlag,
   input wire logic dataValidMark,
   input wire logic [fdi_pkg::GROUPS-1:0] posDataStrobe,
   input wire logic [fdi_pkg::GROUPS-1:0] negDataStrobe,
   // Drivers
   input wire logic devOe,
   input wire logic hubOe,
   input wire logic devValid,
   input wire logic hubValid
);
   import fdi_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence s_pos;
      (posDataStrobe == 4'hf && negDataStrobe == 4'h0) ##1 (posDataStrobe == 4'h0);
   endsequence
   sequence s_neg;
      (negDataStrobe == 4'hf && posDataStrobe == 4'h0) ##1 (negDataStrobe == 4'h0);
   endsequence
   property p_quad;
      $rose(dataValidMark) |-> ##2 s_pos ##1 s_neg ##1 s_pos ##1 s_neg;
   endproperty
   a_quad: assert property (p_quad) else $error("strobe beat order wrong");
   property p_valid_span;
      $rose(dataValidMark) |-> ##1 dataValidMark [*8] ##1 !dataValidMark;
   endproperty
   a_valid_span: assert property (p_valid_span) else $error("valid span wrong");
   property p_strobe_hold;
      ($rose(|posDataStrobe) || $rose(|negDataStrobe)) |->
         $stable(data) && $stable(groupPolarityFlag);
   endproperty
   a_strobe_hold: assert property (p_strobe_hold) else $error("data moved at strobe");
   property p_strobe_idle;
      !dataValidMark |-> posDataStrobe == 4'h0 && negDataStrobe == 4'h0;
   endproperty
   a_strobe_idle: assert property (p_strobe_idle) else $error("strobe while idle");
   property p_dev_valid;
      devOe |-> devValid;
   endproperty
   a_dev_valid: assert property (p_dev_valid) else $error("device drives unmarked");
   property p_hub_valid;
      hubOe |-> hubValid;
   endproperty
   a_hub_valid: assert property (p_hub_valid) else $error("hub drives unmarked");
   property p_one_driver;
      !(devOe && hubOe);
   endproperty
   a_one_driver: assert property (p_one_driver) else $error("both ends drive");
   property p_inv_limit(int g);
      dataValidMark && $past(dataValidMark) |->
         $countones(data[g*16+:16] ^ $past(data[g*16+:16])) <= HALF_GROUP;
   endproperty
   for (genvar g = 0; g < GROUPS; g++)
   begin : gInv
      a_inv_limit: assert property (p_inv_limit(g)) else $error("group flips too many");
   end
endmodule
`default_nettype wire

// ### dv/fsb_data_inversion_strobe_path_bench.sv
// Purpose: Both ends face each other; words cross both ways.
// Assumes: Each send yields four captured beats at the far end, except the one sent while the power cut is up.
// Notes: Expected beats are queued by the sender and popped by monitors.
`timescale 1ns/1ps
`default_nettype none
module fsb_data_inversion_strobe_path_bench;
   import fdi_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic dSendValid = 1'b0;
   logic hSendValid = 1'b0;
   logic [DATA_W-1:0] dSendWord = '0;
   logic [DATA_W-1:0] hSendWord = '0;
   logic askDeepSleep = 1'b0;
   logic askPowerCut = 1'b0;
   logic dSendReady, hSendReady, dRecvValid, hRecvValid, deepSleep, inputBufOff;
   logic [DATA_W-1:0] dRecvWord, hRecvWord;
   logic [DATA_W-1:0] devExp[$];
   logic [DATA_W-1:0] hubExp[$];
   logic [DATA_W+GROUPS-1:0] linkExp[$];
   logic [DATA_W-1:0] devLast = '0;
   logic [DATA_W-1:0] hubLast = '0;
   logic [DATA_W-1:0] noteBus;
   logic [GROUPS-1:0] notePol;
   logic prevMark = 1'b0;
   int failCount = 0;
   int nCompared = 0;
   int cycles = 0;
   always #4 clk = ~clk;
   fdi_link_if fdi_link_if_inst();
   fdi_dev_end fdi_dev_end_inst (.link(fdi_link_if_inst), .clk(clk), .nrst(nrst),
      .sendValid(dSendValid), .sendWord(dSendWord), .sendReady(dSendReady),
      .recvWord(dRecvWord), .recvValid(dRecvValid), .deepSleep(deepSleep),
      .inputBufOff(inputBufOff));
   fdi_hub_end fdi_hub_end_inst (.link(fdi_link_if_inst), .clk(clk), .nrst(nrst),
      .sendValid(hSendValid), .sendWord(hSendWord), .sendReady(hSendReady),
      .recvWord(hRecvWord), .recvValid(hRecvValid), .askDeepSleep(askDeepSleep),
      .askPowerCut(askPowerCut));
   fdi_link_chk fdi_link_chk_inst (.clk(clk), .nrst(nrst), .data(fdi_link_if_inst.data),
      .groupPolarityFlag(fdi_link_if_inst.groupPolarityFlag),
      .dataValidMark(fdi_link_if_inst.dataValidMark),
      .posDataStrobe(fdi_link_if_inst.posDataStrobe),
      .negDataStrobe(fdi_link_if_inst.negDataStrobe), .devOe(fdi_link_if_inst.devOe),
      .hubOe(fdi_link_if_inst.hubOe), .devValid(fdi_link_if_inst.devValid),
      .hubValid(fdi_link_if_inst.hubValid));
   task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
      nCompared++;
      if (seen !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         failCount++;
      end
   endtask
   task automatic tally_and_finish();
      if (failCount == 0 && nCompared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Sender holds the request until ready is sampled, then lets one edge pass.
   task automatic send(input bit fromDev, input logic [DATA_W-1:0] w, input bit expectRx);
      logic [DATA_W-1:0] prev;
      logic [DATA_W-1:0] bus;
      logic [GROUPS-1:0] pol;
      int i;
      // The first beat's flags follow from the sender's last bus value and the flip count.
      prev = fromDev ? devLast : hubLast;
      for (i = 0; i < GROUPS; i++)
      begin
         pol[i] = $countones(w[i*GROUP_W +: GROUP_W] ^ prev[i*GROUP_W +: GROUP_W]) > HALF_GROUP;
         bus[i*GROUP_W +: GROUP_W] = pol[i] ? ~w[i*GROUP_W +: GROUP_W] : w[i*GROUP_W +: GROUP_W];
      end
      linkExp.push_back({bus, pol});
      if (fromDev)
         devLast = bus;
      else
         hubLast = bus;
      for (i = 0; i < BEATS && expectRx; i++)
      begin
         if (fromDev)
            hubExp.push_back(w);
         else
            devExp.push_back(w);
      end
      if (fromDev)
      begin
         dSendValid <= 1'b1;
         dSendWord <= w;
      end
      else
      begin
         hSendValid <= 1'b1;
         hSendWord <= w;
      end
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if ((fromDev ? dSendReady : hSendReady) === 1'b1)
            break;
      end
      check("sendReady", {63'h0, fromDev ? dSendReady : hSendReady}, 64'h1);
      dSendValid <= 1'b0;
      hSendValid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic waitLevel(input string what, input bit useBuf, input logic lvl);
      int i;
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         if ((useBuf ? inputBufOff : deepSleep) === lvl)
            break;
      end
      check(what, {63'h0, useBuf ? inputBufOff : deepSleep}, {63'h0, lvl});
   endtask
   always @(posedge clk)
   begin
      prevMark <= fdi_link_if_inst.dataValidMark;
      if (fdi_link_if_inst.dataValidMark === 1'b1 && prevMark === 1'b0)
      begin
         if (linkExp.size() == 0)
            check("linkExtra", 64'h1, 64'h0);
         else
         begin
            {noteBus, notePol} = linkExp.pop_front();
            check("linkData", fdi_link_if_inst.data, noteBus);
            check("linkPolarity", 64'(fdi_link_if_inst.groupPolarityFlag), 64'(notePol));
         end
      end
      if (hRecvValid === 1'b1)
      begin
         if (hubExp.size() == 0)
            check("hubRecvExtra", 64'h1, 64'h0);
         else
            check("hubRecvWord", hRecvWord, hubExp.pop_front());
      end
      if (dRecvValid === 1'b1)
      begin
         if (devExp.size() == 0)
            check("devRecvExtra", 64'h1, 64'h0);
         else
            check("devRecvWord", dRecvWord, devExp.pop_front());
      end
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         failCount++;
         tally_and_finish();
      end
   end
   initial
   begin
      logic [DATA_W-1:0] tbl[4];
      int k;
      tbl = '{64'h0000_0000_0000_0000, 64'hffff_ffff_ffff_ffff,
              64'h00ff_01ff_0000_fe00, 64'h5555_aaaa_1234_fedc};
      void'($urandom(32'h05db_a4b7));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check("deepSleepAtReset", {63'h0, deepSleep}, 64'h0);
      // Boundary flip counts per group, both directions, back to back.
      for (k = 0; k < 8; k++)
         send(k[0], tbl[k/2], 1'b1);
      for (k = 0; k < 12; k++)
         send(1'($urandom % 2), {$urandom, $urandom}, 1'b1);
      askDeepSleep <= 1'b1;
      waitLevel("deepSleepEnter", 1'b0, 1'b1);
      askDeepSleep <= 1'b0;
      waitLevel("deepSleepLeave", 1'b0, 1'b0);
      askPowerCut <= 1'b1;
      waitLevel("bufOffOn", 1'b1, 1'b1);
      send(1'b0, {$urandom, $urandom}, 1'b0);
      repeat (12) @(posedge clk);
      askPowerCut <= 1'b0;
      waitLevel("bufOffOff", 1'b1, 1'b0);
      send(1'b0, ~tbl[3], 1'b1);
      repeat (20) @(posedge clk);
      check("hubLeft", 64'(hubExp.size()), 64'h0);
      check("devLeft", 64'(devExp.size()), 64'h0);
      check("linkLeft", 64'(linkExp.size()), 64'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
